// ---- rtl/nrp_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// Operation
// R1 - Device powers up with read setup latched
// R2 - Read: 00h, five addresses, 30h, then wait
// R3 - Device outputs one byte per read strobe
// R4 - Output starts at column, increments per strobe
// R5 - Random data output jumps column repeatedly
// R6 - Never program one page twice without erase; the code refuses only a repeat of the last confirmed page
// R7 - Program pages of a block in ascending order; the code checks only against the last confirmed page, and only in its block
// R8 - Program: 80h, five addresses, data bytes
// R9 - Random data input moves load pointer
// R10 - Confirm without data starts no programming
// R11 - Busy device accepts only status and reset
// R12 - Completion shown on ready pin and bit six
// R13 - Status bit zero gives pass or fail
// R14 - Status mode holds until next command
// R15 - Cache confirm frees cache register quickly
// R16 - Cache program sequence stays in one block
// R17 - Bit six cache ready, bit five true ready
// R18 - Cache pass/fail is the previous page
// R19 - Cache transfer waits for pending program
// R20 - Ready-pin-only host ends cache with 10h
// R21 - Fourth ID byte field encoding
// R22 - Fifth ID byte field encoding
// R23 - Status: fail one, ready one, protect zero
// R24 - No data or array command until ready
module nrp_host
(
    // Clock, reset and enable.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Memory pins.
    output logic             ce_n,
    output logic             cle,
    output logic             ale,
    output logic             we_n,
    output logic             read_strobe_n,
    output logic             wp_n,
    input  wire logic [7:0]  io_in,
    output logic      [7:0]  io_out,
    output logic             io_oe_n,
    input  wire logic        rb_n
);
    nrp_pkg::nrp_state_e              state_reg, state_next;
    nrp_pkg::nrp_kind_e               kind_reg, kind_next;
    nrp_pkg::nrp_pins_s               pins_reg, pins_next;
    logic [7:0]                       byte_reg, byte_next;
    logic [3:0]                       cnt_reg, cnt_next;
    logic [7:0]                       rd_reg, rd_next;
    logic                             err_reg, err_next;
    logic                             status_mode_reg, status_mode_next;
    logic                             prog_open_reg, prog_open_next;
    logic                             row_cap_reg, row_cap_next;
    logic                             loaded_reg, loaded_next;
    logic                             cache_open_reg, cache_open_next;
    logic                             last_valid_reg, last_valid_next;
    logic [2:0]                       addr_idx_reg, addr_idx_next;
    logic [nrp_pkg::ROW_W-1:0]        row_reg, row_next;
    logic [nrp_pkg::ROW_W-1:0]        last_row_reg, last_row_next;
    logic [1:0]                       rb_sync;
    logic [7:0]                       io_s1, io_s2;
    logic                             rb_ok;
    logic                             go, cyc_wr, is_conf, same_blk, order_bad, repeat_bad;
    logic                             cache_bad, wait_bad, refuse;
    nrp_pkg::nrp_kind_e               go_kind;
    logic [7:0]                       go_byte;

    // Commands that a busy device would ignore must wait for ready.
    function automatic logic needs_ready(input nrp_pkg::nrp_kind_e k, input logic [7:0] b,
                                         input logic st_mode);
        if (k == nrp_pkg::NRP_K_CMD)
            needs_ready = (b != nrp_pkg::CMD_STATUS) && (b != nrp_pkg::CMD_RESET);
        else if (k == nrp_pkg::NRP_K_RDATA)
            needs_ready = !st_mode;
        else
            needs_ready = k == nrp_pkg::NRP_K_WAIT;
    endfunction

    function automatic logic is_write_kind(input nrp_pkg::nrp_kind_e k);
        is_write_kind = (k == nrp_pkg::NRP_K_CMD) || (k == nrp_pkg::NRP_K_ADDR)
                        || (k == nrp_pkg::NRP_K_WDATA);
    endfunction

    // Ready pin and data bus come from outside the clock domain.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rb_sync <= 2'h0;
            io_s1   <= 8'h00;
            io_s2   <= 8'h00;
        end
        else if (clk_en)
        begin
            rb_sync <= {rb_sync[0], rb_n};
            io_s1   <= io_in;
            io_s2   <= io_s1;
        end
    end
    assign rb_ok = rb_sync[1]; // R12

    assign cyc_wr  = psel && penable && pwrite && (paddr == nrp_pkg::OFF_CYCLE);
    assign go      = cyc_wr && (state_reg == nrp_pkg::NRP_IDLE) && clk_en;
    assign go_kind = nrp_pkg::nrp_kind_e'(pwdata[nrp_pkg::CYC_KIND_LSB +: 3]);
    assign go_byte = pwdata[7:0];
    assign is_conf = (go_kind == nrp_pkg::NRP_K_CMD) && prog_open_reg && loaded_reg
                     && ((go_byte == nrp_pkg::CMD_PROG_CONF)
                     || (go_byte == nrp_pkg::CMD_CACHE_CONF)); // R10
    assign same_blk = row_reg[nrp_pkg::ROW_W-1:nrp_pkg::PAGE_W]
                      == last_row_reg[nrp_pkg::ROW_W-1:nrp_pkg::PAGE_W];
    assign order_bad  = is_conf && last_valid_reg && same_blk
                        && (row_reg[nrp_pkg::PAGE_W-1:0] < last_row_reg[nrp_pkg::PAGE_W-1:0]); // R7
    assign repeat_bad = is_conf && last_valid_reg && (row_reg == last_row_reg); // R6
    assign cache_bad  = is_conf && cache_open_reg && !same_blk; // R16
    assign wait_bad   = go_kind == nrp_pkg::NRP_K_WAIT && cache_open_reg; // R20
    assign refuse     = order_bad || repeat_bad || cache_bad || wait_bad;

    always_comb
    begin
        state_next       = state_reg;
        kind_next        = kind_reg;
        byte_next        = byte_reg;
        pins_next        = pins_reg;
        cnt_next         = cnt_reg;
        rd_next          = rd_reg;
        err_next         = err_reg;
        status_mode_next = status_mode_reg;
        prog_open_next   = prog_open_reg;
        row_cap_next     = row_cap_reg;
        loaded_next      = loaded_reg;
        cache_open_next  = cache_open_reg;
        last_valid_next  = last_valid_reg;
        addr_idx_next    = addr_idx_reg;
        row_next         = row_reg;
        last_row_next    = last_row_reg;
        if (psel && penable && !pwrite && paddr == nrp_pkg::OFF_STATUS)
            err_next = 1'b0;
        unique case (state_reg)
            nrp_pkg::NRP_IDLE:
            begin
                if (go && !refuse)
                begin
                    kind_next  = go_kind;
                    byte_next  = go_byte;
                    state_next = nrp_pkg::NRP_SETUP;
                    if (go_kind == nrp_pkg::NRP_K_CMD)
                    begin
                        status_mode_next = go_byte == nrp_pkg::CMD_STATUS; // R14
                        addr_idx_next    = 3'h0;
                        row_cap_next     = go_byte == nrp_pkg::CMD_DATA_IN;
                        if (go_byte == nrp_pkg::CMD_DATA_IN)
                        begin
                            prog_open_next = 1'b1; // R8
                            loaded_next    = 1'b0;
                        end
                        else if (is_conf)
                        begin
                            prog_open_next  = 1'b0;
                            last_valid_next = 1'b1;
                            last_row_next   = row_reg;
                            cache_open_next = go_byte == nrp_pkg::CMD_CACHE_CONF; // R15
                        end
                        else if (go_byte != nrp_pkg::CMD_STATUS && go_byte != nrp_pkg::CMD_RAND_IN)
                            prog_open_next = 1'b0;
                    end
                    else if (go_kind == nrp_pkg::NRP_K_ADDR)
                    begin
                        addr_idx_next = addr_idx_reg + 3'h1;
                        if (row_cap_reg && addr_idx_reg == nrp_pkg::ADDR_ROW1)
                            row_next[7:0] = go_byte;
                        if (row_cap_reg && addr_idx_reg == nrp_pkg::ADDR_ROW2)
                            row_next[15:8] = go_byte;
                        if (row_cap_reg && addr_idx_reg == nrp_pkg::ADDR_ROW3)
                            row_next[nrp_pkg::ROW_W-1:16] = go_byte[1:0];
                    end
                    else if (go_kind == nrp_pkg::NRP_K_WDATA && prog_open_reg)
                        loaded_next = 1'b1; // R9
                end
            end
            nrp_pkg::NRP_SETUP:
            begin
                if (!needs_ready(kind_reg, byte_reg, status_mode_reg) || rb_ok) // R24
                begin
                    if (kind_reg == nrp_pkg::NRP_K_WAIT)
                        state_next = nrp_pkg::NRP_IDLE;
                    else
                    begin
                        pins_next.ce_n          = 1'b0;
                        pins_next.cle           = kind_reg == nrp_pkg::NRP_K_CMD;
                        pins_next.ale           = kind_reg == nrp_pkg::NRP_K_ADDR;
                        pins_next.io_out        = byte_reg;
                        pins_next.io_oe_n       = !is_write_kind(kind_reg);
                        pins_next.we_n          = !is_write_kind(kind_reg);
                        pins_next.read_strobe_n = is_write_kind(kind_reg); // R3
                        cnt_next   = is_write_kind(kind_reg) ? nrp_pkg::LOW_CYC - 4'h1
                                                             : nrp_pkg::READ_LOW_CYC - 4'h1;
                        state_next = nrp_pkg::NRP_LOW;
                    end
                end
            end
            nrp_pkg::NRP_LOW:
            begin
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h0)
                begin
                    if (kind_reg == nrp_pkg::NRP_K_RDATA)
                        rd_next = io_s2; // R4
                    pins_next.we_n          = 1'b1;
                    pins_next.read_strobe_n = 1'b1;
                    cnt_next   = nrp_pkg::HIGH_CYC - 4'h1;
                    state_next = nrp_pkg::NRP_HIGH;
                end
            end
            nrp_pkg::NRP_HIGH:
            begin
                cnt_next = cnt_reg - 4'h1;
                if (cnt_reg == 4'h0)
                begin
                    pins_next  = nrp_pkg::PINS_IDLE;
                    state_next = nrp_pkg::NRP_IDLE;
                end
            end
        endcase
        // A refusal in the same cycle as the clearing read still sets the flag.
        if (go && refuse)
            err_next = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg       <= nrp_pkg::NRP_IDLE;
            kind_reg        <= nrp_pkg::NRP_K_CMD;
            byte_reg        <= 8'h00;
            pins_reg        <= nrp_pkg::PINS_IDLE;
            cnt_reg         <= 4'h0;
            rd_reg          <= 8'h00;
            err_reg         <= 1'b0;
            status_mode_reg <= 1'b0;
            prog_open_reg   <= 1'b0;
            row_cap_reg     <= 1'b0;
            loaded_reg      <= 1'b0;
            cache_open_reg  <= 1'b0;
            last_valid_reg  <= 1'b0;
            addr_idx_reg    <= 3'h0;
            row_reg         <= '0;
            last_row_reg    <= '0;
        end
        else if (clk_en)
        begin
            state_reg       <= state_next;
            kind_reg        <= kind_next;
            byte_reg        <= byte_next;
            pins_reg        <= pins_next;
            cnt_reg         <= cnt_next;
            rd_reg          <= rd_next;
            err_reg         <= err_next;
            status_mode_reg <= status_mode_next;
            prog_open_reg   <= prog_open_next;
            row_cap_reg     <= row_cap_next;
            loaded_reg      <= loaded_next;
            cache_open_reg  <= cache_open_next;
            last_valid_reg  <= last_valid_next;
            addr_idx_reg    <= addr_idx_next;
            row_reg         <= row_next;
            last_row_reg    <= last_row_next;
        end
    end

    assign ce_n          = pins_reg.ce_n;
    assign cle           = pins_reg.cle;
    assign ale           = pins_reg.ale;
    assign we_n          = pins_reg.we_n;
    assign read_strobe_n = pins_reg.read_strobe_n;
    assign io_out        = pins_reg.io_out;
    assign io_oe_n       = pins_reg.io_oe_n;
    assign wp_n          = 1'b1;

    // A cycle write waits while the engine is busy, so software needs no polling.
    assign pready = !(cyc_wr && !go);

    always_comb
    begin
        prdata  = nrp_pkg::RESET_WORD;
        pslverr = 1'b0;
        unique case (paddr)
            nrp_pkg::OFF_CYCLE:  prdata = {24'h0, byte_reg};
            nrp_pkg::OFF_STATUS: prdata = {16'h0, rd_reg, 5'h0, err_reg, rb_ok,
                                           state_reg != nrp_pkg::NRP_IDLE}; // R23
            // Fourth ID byte: page, spare, block, width, access speed.
            nrp_pkg::OFF_ID4:    prdata = {5'h0, rd_reg[7], rd_reg[3], rd_reg[6],
                                           6'h0, rd_reg[5:4], 7'h0, rd_reg[2], 6'h0,
                                           rd_reg[1:0]}; // R21
            // Fifth ID byte: plane count and plane size.
            nrp_pkg::OFF_ID5:    prdata = {21'h0, rd_reg[6:4], 6'h0, rd_reg[3:2]}; // R22
            default:             pslverr = psel && penable;
        endcase
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    page_order_a: assert property (go && order_bad |=> err_reg && state_reg == nrp_pkg::NRP_IDLE) // R7
        else $error("Descending page program was not refused.");
    page_repeat_a: assert property (go && repeat_bad |=> ##[0:2] $stable(pins_reg.cle) && !cle) // R6
        else $error("Repeated page program reached the pins.");
    cache_block_a: assert property (go && cache_bad |=> err_reg throughout (##[0:3] 1'b1)) // R16
        else $error("Cache program across blocks was not refused.");
    cache_end_a: assert property (go && wait_bad |-> ##1 state_reg == nrp_pkg::NRP_IDLE [*2]) // R20
        else $error("Ready-pin wait allowed inside an open cache sequence.");
    ready_gate_a: assert property ($fell(read_strobe_n) && !status_mode_reg |-> $past(rb_ok)) // R24
        else $error("Data strobed out while the device was busy.");
    cmd_gate_a: assert property ($fell(we_n) && cle && byte_reg != nrp_pkg::CMD_STATUS // R11
        && byte_reg != nrp_pkg::CMD_RESET |-> $past(rb_ok)) else $error("Command sent while busy.");

    read_cov_c:  cover property ($fell(read_strobe_n) ##[1:8] $rose(read_strobe_n));
    conf_cov_c:  cover property (go && is_conf && go_byte == nrp_pkg::CMD_PROG_CONF);
    cache_cov_c: cover property (go && is_conf && go_byte == nrp_pkg::CMD_CACHE_CONF);
endmodule
`default_nettype wire

// ---- rtl/nrp_pkg.sv ----
`default_nettype none
package nrp_pkg;
    // Clock and strobe timing.
    localparam int CLK_PERIOD_NS  = 10;
    localparam int STROBE_LOW_NS  = 15;
    localparam int STROBE_HIGH_NS = 10;
    localparam int SYNC_STAGES    = 2;
    localparam logic [3:0] LOW_CYC  = 4'((STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] HIGH_CYC = 4'((STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] READ_LOW_CYC = 4'(int'(LOW_CYC) + SYNC_STAGES);
    // Command bytes.
    localparam logic [7:0] CMD_READ_SETUP  = 8'h00;
    localparam logic [7:0] CMD_READ_CONF   = 8'h30;
    localparam logic [7:0] CMD_RAND_OUT    = 8'h05;
    localparam logic [7:0] CMD_RAND_OUT_CF = 8'hE0;
    localparam logic [7:0] CMD_DATA_IN     = 8'h80;
    localparam logic [7:0] CMD_RAND_IN     = 8'h85;
    localparam logic [7:0] CMD_PROG_CONF   = 8'h10;
    localparam logic [7:0] CMD_CACHE_CONF  = 8'h15;
    localparam logic [7:0] CMD_STATUS      = 8'h70;
    localparam logic [7:0] CMD_RESET       = 8'hFF;
    // Row address layout: page in the low bits, block above.
    localparam int ROW_W   = 18;
    localparam int PAGE_W  = 6;
    localparam int BLOCK_W = ROW_W - PAGE_W;
    localparam logic [2:0] ADDR_ROW1 = 3'h2;
    localparam logic [2:0] ADDR_ROW2 = 3'h3;
    localparam logic [2:0] ADDR_ROW3 = 3'h4;
    // Register offsets.
    localparam logic [7:0] OFF_CYCLE  = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_ID4    = 8'h08;
    localparam logic [7:0] OFF_ID5    = 8'h0C;
    // Cycle and status register fields.
    localparam int CYC_KIND_LSB = 8;
    localparam int STS_ERR_BIT  = 2;
    localparam int STS_BYTE_LSB = 8;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic [2:0]
    {
        NRP_K_CMD   = 3'b000,
        NRP_K_ADDR  = 3'b001,
        NRP_K_WDATA = 3'b010,
        NRP_K_RDATA = 3'b011,
        NRP_K_WAIT  = 3'b100
    } nrp_kind_e;

    typedef enum logic [1:0]
    {
        NRP_IDLE  = 2'b00,
        NRP_SETUP = 2'b01,
        NRP_LOW   = 2'b10,
        NRP_HIGH  = 2'b11
    } nrp_state_e;

    typedef struct packed
    {
        logic       ce_n;
        logic       cle;
        logic       ale;
        logic       we_n;
        logic       read_strobe_n;
        logic       io_oe_n;
        logic [7:0] io_out;
    } nrp_pins_s;

    localparam nrp_pins_s PINS_IDLE = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00};
endpackage
`default_nettype wire

// ---- verification/nrp_flash_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module nrp_flash_model
#(
    parameter int T_READ_NS = 300,
    parameter int T_PROG_NS = 900,
    parameter int T_CBSY_NS = 100
)
(
    // Strobes and data from the controller, and the row whose program fails.
    input  wire logic        ce_n,
    input  wire logic        cle,
    input  wire logic        ale,
    input  wire logic        we_n,
    input  wire logic        read_strobe_n,
    input  wire logic [7:0]  io_out,
    input  wire logic [17:0] fail_row,
    // Lines back to the controller.
    output logic      [7:0]  io_in,
    output logic             rb_n
);
    logic [7:0] mem [int];
    logic [7:0] cache [0:2111];
    logic [7:0] adr [0:4];
    logic [7:0] last_cmd = 8'h00;
    logic       busy = 1'b0;
    logic       arr_busy = 1'b0;
    logic       loaded = 1'b0;
    logic       status_mode = 1'b0;
    logic       last_fail = 1'b0;
    int         na = 0;
    int         col = 0;
    int         row = 0;
    assign rb_n = ~busy;
    initial io_in = 8'hA5;
    function automatic logic [7:0] pat(input int r, input int c);
        return 8'(r ^ c ^ 8'h5A);
    endfunction
    task automatic run_read(input int r);
        busy = 1'b1;
        #(T_READ_NS);
        for (int i = 0; i < 2112; i++)
            cache[i] = mem.exists(r * 4096 + i) ? mem[r * 4096 + i] : pat(r, i);
        busy = 1'b0;
    endtask
    // The page is copied at confirm so the cache can take new data at once.
    task automatic run_prog(input int r, input logic cached);
        logic [7:0] d [0:2111];
        d = cache;
        busy = 1'b1;
        wait (!arr_busy);
        arr_busy = 1'b1;
        if (cached)
            #(T_CBSY_NS) busy = 1'b0;
        #(T_PROG_NS);
        for (int i = 0; i < 2112; i++)
            mem[r * 4096 + i] = d[i];
        last_fail = (r == int'(fail_row));
        arr_busy = 1'b0;
        if (!cached)
            busy = 1'b0;
    endtask
    always @(negedge read_strobe_n)
    begin
        if (status_mode)
            io_in = {1'b1, ~busy, ~arr_busy, 4'h0, last_fail};
        else
        begin
            io_in = cache[col];
            col = (col < 2111) ? col + 1 : col;
        end
    end
    // No pull-up on the bus, so a released bus shows the inverse of its last byte.
    always @(posedge read_strobe_n)
        io_in = ~io_in;
    always @(posedge we_n)
    begin
        if (!ce_n && cle)
        begin
            if (!busy || io_out == nrp_pkg::CMD_STATUS || io_out == nrp_pkg::CMD_RESET)
            begin
                status_mode = (io_out == nrp_pkg::CMD_STATUS);
                case (io_out)
                    nrp_pkg::CMD_READ_CONF:
                        fork
                            run_read(row);
                        join_none
                    nrp_pkg::CMD_PROG_CONF, nrp_pkg::CMD_CACHE_CONF:
                        if (loaded)
                        begin
                            loaded = 1'b0;
                            fork
                                run_prog(row, io_out == nrp_pkg::CMD_CACHE_CONF);
                            join_none
                        end
                    default:
                    begin
                        last_cmd = io_out;
                        na = 0;
                        loaded = loaded && io_out != nrp_pkg::CMD_DATA_IN;
                    end
                endcase
            end
        end
        else if (!ce_n && ale)
        begin
            adr[na % 5] = io_out;
            na++;
            if (na == 2)
                col = int'({adr[1][3:0], adr[0]});
            if (na == 5)
                row = int'({adr[4][1:0], adr[3], adr[2]});
        end
        else if (!ce_n && (last_cmd == nrp_pkg::CMD_DATA_IN
                 || last_cmd == nrp_pkg::CMD_RAND_IN))
        begin
            cache[col] = io_out;
            col = (col < 2111) ? col + 1 : col;
            loaded = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- verification/nrp_host_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module nrp_host_tb;
    localparam int LIMIT = 30000;
    logic        pclk;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ce_n, cle, ale, we_n, read_strobe_n, rb_n;
    logic [7:0]  io_out;
    logic [7:0]  io_in;
    logic [31:0] sts;
    logic        refl = 1'b0;
    int          num_errors = 0;
    int          checks = 0;
    int          cycles = 0;
    nrp_host u_dut
    (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .read_strobe_n(read_strobe_n), .wp_n(), .io_in(io_in), .io_out(io_out),
        .io_oe_n(), .rb_n(rb_n)
    );
    nrp_flash_model u_mem
    (
        .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n),
        .io_out(io_out), .fail_row(18'd129), .io_in(io_in), .rb_n(rb_n)
    );
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            num_errors++;
            wrap_up();
        end
    end
    function automatic logic [7:0] pat(input int r, input int c);
        return 8'(r ^ c ^ 8'h5A);
    endfunction
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cyc(input nrp_pkg::nrp_kind_e k, input logic [7:0] b);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, nrp_pkg::OFF_CYCLE, {21'h0, k, b}, rd, e);
    endtask
    task automatic cmd(input logic [7:0] b);
        cyc(nrp_pkg::NRP_K_CMD, b);
    endtask
    // Reading STATUS clears the refusal flag, so every poll folds it into refl.
    task automatic poll_idle();
        logic e;
        int   n;
        n = 0;
        do
        begin
            apb(1'b0, nrp_pkg::OFF_STATUS, 32'h0, sts, e);
            refl |= sts[nrp_pkg::STS_ERR_BIT];
            n++;
        end
        while (sts[0] === 1'b1 && n < 300);
    endtask
    task automatic rd_get(output logic [7:0] b);
        cyc(nrp_pkg::NRP_K_RDATA, 8'h00);
        poll_idle();
        b = sts[15:8];
    endtask
    task automatic rd_chk(input logic [7:0] exp);
        logic [7:0] b;
        rd_get(b);
        chk_word({24'h0, b}, {24'h0, exp});
    endtask
    task automatic wait_ready(output logic [7:0] b);
        cmd(nrp_pkg::CMD_STATUS);
        b = 8'h00;
        for (int n = 0; n < 80 && b[6] !== 1'b1; n++)
            rd_get(b);
    endtask
    task automatic refusal(input logic exp);
        poll_idle();
        chk_bit(refl, exp);
        refl = 1'b0;
    endtask
    task automatic addr(input logic [11:0] c, input logic [17:0] r, input int n);
        cyc(nrp_pkg::NRP_K_ADDR, c[7:0]);
        cyc(nrp_pkg::NRP_K_ADDR, {4'h0, c[11:8]});
        for (int i = 2; i < n; i++)
            cyc(nrp_pkg::NRP_K_ADDR, 8'(r >> (8 * (i - 2))));
    endtask
    task automatic load(input logic [17:0] r, input int n, input logic [7:0] base);
        cmd(nrp_pkg::CMD_DATA_IN);
        addr(12'h000, r, 5);
        for (int i = 0; i < n; i++)
            cyc(nrp_pkg::NRP_K_WDATA, base + 8'(i));
    endtask
    task automatic read_page(input logic [17:0] r, input logic [11:0] c);
        cmd(nrp_pkg::CMD_READ_SETUP);
        addr(c, r, 5);
        cmd(nrp_pkg::CMD_READ_CONF);
    endtask
    task automatic jump(input logic [11:0] c);
        cmd(nrp_pkg::CMD_RAND_OUT);
        addr(c, 18'h0, 2);
        cmd(nrp_pkg::CMD_RAND_OUT_CF);
    endtask
    initial
    begin
        logic [31:0] d;
        logic        e;
        logic [7:0]  b;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, nrp_pkg::OFF_STATUS, 32'h0, d, e);
        chk_word(d, 32'h0000_0002);
        apb(1'b0, 8'h40, 32'h0, d, e);
        chk_bit(e, 1'b1);
        $display("test reset done");
        addr(12'd5, 18'd3, 5);
        cmd(nrp_pkg::CMD_READ_CONF);
        for (int i = 0; i < 3; i++)
            rd_chk(pat(3, 5 + i));
        for (int c = 2110; c >= 0; c -= 2110)
        begin
            jump(12'(c));
            rd_chk(pat(3, c));
            rd_chk(pat(3, c + 1));
        end
        $display("test page read done");
        load(18'd66, 4, 8'h92);
        cmd(nrp_pkg::CMD_RAND_IN);
        addr(12'd100, 18'h0, 2);
        cyc(nrp_pkg::NRP_K_WDATA, 8'h30);
        cmd(nrp_pkg::CMD_PROG_CONF);
        cmd(nrp_pkg::CMD_STATUS);
        rd_chk(8'h80);
        cyc(nrp_pkg::NRP_K_WAIT, 8'h00);
        rd_chk(8'hE0);
        read_page(18'd66, 12'd100);
        rd_chk(8'h30);
        jump(12'd0);
        for (int i = 0; i < 4; i++)
            rd_chk(8'h92 + 8'(i));
        apb(1'b0, nrp_pkg::OFF_ID4, 32'h0, d, e);
        chk_word(d, 32'h0401_0101);
        apb(1'b0, nrp_pkg::OFF_ID5, 32'h0, d, e);
        chk_word(d, 32'h0000_0101);
        cmd(nrp_pkg::CMD_PROG_CONF);
        wait_ready(b);
        chk_word({24'h0, b}, 32'h0000_00E0);
        refusal(1'b0);
        $display("test page program done");
        for (int p = 66; p >= 65; p--)
        begin
            load(18'(p), 1, 8'h00);
            cmd(nrp_pkg::CMD_PROG_CONF);
            refusal(1'b1);
        end
        $display("test page order done");
        load(18'd129, 2, 8'h40);
        cmd(nrp_pkg::CMD_CACHE_CONF);
        load(18'd130, 2, 8'h50);
        cmd(nrp_pkg::CMD_CACHE_CONF);
        wait_ready(b);
        chk_word({24'h0, b}, 32'h0000_00C1);
        cyc(nrp_pkg::NRP_K_WAIT, 8'h00);
        refusal(1'b1);
        load(18'd192, 1, 8'h00);
        cmd(nrp_pkg::CMD_CACHE_CONF);
        refusal(1'b1);
        load(18'd131, 2, 8'h60);
        cmd(nrp_pkg::CMD_PROG_CONF);
        wait_ready(b);
        chk_word({24'h0, b}, 32'h0000_00E0);
        refusal(1'b0);
        read_page(18'd130, 12'd1);
        rd_chk(8'h51);
        $display("test cache program done");
        wrap_up();
    end
endmodule
`default_nettype wire
